// [dci_pkg.sv]
// What this block and the software using it must do
// RQ1 - Read-only 16-bit count of fetched items
// RQ2 - Item count returns to zero at completion
// RQ3 - Next addresses from start, count, steps, width
// RQ4 - Source start held as two 16-bit halves
// RQ5 - Destination start held as two 16-bit halves
// RQ6 - Interrupt when match count equals index, pre-advance
// RQ7 - Interrupt only with interrupt enable bit set
// RQ8 - Length value N moves N plus one items
// RQ9 - Bit 13 picks level or rising-edge requests
// RQ10 - Bit 12 fills destination from one source fetch
// RQ11 - Software enables destination step in fill mode
// RQ12 - Fill mode keeps bus, no preemption
// RQ13 - Software avoids fill with peripheral triggering
// RQ14 - Bit 11 low: back to back, bus locked
// RQ15 - Bit 11 high: one idle cycle per store
// RQ16 - Peripheral trigger mode ignores bit 11
// RQ17 - Width field gives 1, 2, 4 byte items
// RQ18 - Run bit clears at normal-mode completion
// RQ19 - Circular triggered mode restarts with index reset
// RQ20 - Trigger bit picks immediate or paced start
package dci_pkg;

    // Printed register addresses, two bytes apart; slotOf turns each into its index
    localparam logic [31:0] OFF_ITEM_INDEX = 32'h5000361E;
    localparam logic [31:0] OFF_SRC_LOW = 32'h50003620;
    localparam logic [31:0] OFF_SRC_HIGH = 32'h50003622;
    localparam logic [31:0] OFF_DST_LOW = 32'h50003624;
    localparam logic [31:0] OFF_DST_HIGH = 32'h50003626;
    localparam logic [31:0] OFF_INT_MATCH = 32'h50003628;
    localparam logic [31:0] OFF_LENGTH = 32'h5000362A;
    localparam logic [31:0] OFF_CONTROL = 32'h5000362C;

    // Avalon word slot of a register: distance from the first, in halfword steps
    function automatic logic [2:0] slotOf(input logic [31:0] off);
        logic [31:0] d;
        d = (off - OFF_ITEM_INDEX) >> 1;
        return d[2:0];
    endfunction

    // Control field positions
    localparam int CTL_ON = 0;
    localparam int CTL_BW_LO = 1;
    localparam int CTL_BW_HI = 2;
    localparam int CTL_IRQ_EN = 3;
    localparam int CTL_TRIG = 4;
    localparam int CTL_DST_INC = 5;
    localparam int CTL_SRC_INC = 6;
    localparam int CTL_CIRC = 7;
    localparam int CTL_PRIO_LO = 8;
    localparam int CTL_PRIO_HI = 10;
    localparam int CTL_YIELD = 11;
    localparam int CTL_FILL = 12;
    localparam int CTL_EDGE = 13;
    localparam logic [15:0] CTL_WMASK = 16'h3FFF;

    // Reset values
    localparam logic [15:0] RST_REG16 = 16'h0000;
    localparam logic [31:0] RST_REG32 = 32'h00000000;

    // Bus width codes
    localparam logic [1:0] BW_BYTE = 2'h0;
    localparam logic [1:0] BW_HALF = 2'h1;
    localparam logic [1:0] BW_WORD = 2'h2;

    typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_WRITE, ST_GAP} dci_state_e;

endpackage

// [dci_channel.sv]
// Implementation choice: register access over Avalon-MM.
`timescale 1ns/1ps
module dci_channel
    import dci_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic [2:0] avsAddress,
    input wire logic avsRead,
    input wire logic avsWrite,
    input wire logic [31:0] avsWriteData,
    input wire logic [3:0] avsByteEnable,
    output logic [31:0] avsReadData,
    output logic avsWaitrequest,
    output logic [31:0] mAddress,
    output logic mRead,
    output logic mWrite,
    output logic [31:0] mWriteData,
    input wire logic [31:0] mReadData,
    input wire logic mWaitrequest,
    output logic [1:0] mSize,
    output logic busLock,
    output logic [2:0] channelPriority,
    input wire logic dmaReq,
    output logic dmaAck,
    output logic irqPulse,
    output logic channelActive
);

    localparam logic [2:0] S_IDX = slotOf(OFF_ITEM_INDEX);
    localparam logic [2:0] S_SRC_LO = slotOf(OFF_SRC_LOW);
    localparam logic [2:0] S_SRC_HI = slotOf(OFF_SRC_HIGH);
    localparam logic [2:0] S_DST_LO = slotOf(OFF_DST_LOW);
    localparam logic [2:0] S_DST_HI = slotOf(OFF_DST_HIGH);
    localparam logic [2:0] S_INT = slotOf(OFF_INT_MATCH);
    localparam logic [2:0] S_LEN = slotOf(OFF_LENGTH);
    localparam logic [2:0] S_CTL = slotOf(OFF_CONTROL);

    logic [15:0] itemIndex;
    logic [15:0] sourceBaseLow;
    logic [15:0] sourceBaseHigh;
    logic [15:0] destBaseLow;
    logic [15:0] destBaseHigh;
    logic [15:0] interruptMatchCount;
    logic [15:0] transferLengthValue;
    logic [15:0] channelControl;
    logic rdValid;
    dci_state_e state;
    logic [31:0] dataHold;
    logic reqPrev;
    logic reqPend;
    logic itemDone;
    logic lastItem;
    logic stopAtEnd;
    logic reqSeen;
    logic startItem;
    logic [1:0] busWidthSelect;
    logic [31:0] stepOffset;
    logic [31:0] srcAddr;
    logic [31:0] dstAddr;
    logic [15:0] ctlMerged;

    // Byte-lane merge for a 16-bit register in the low half of the word
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                            input logic [3:0] be);
        logic [15:0] r;
        r = old;
        if (be[0])
        begin
            r[7:0] = wd[7:0];
        end
        if (be[1])
        begin
            r[15:8] = wd[15:8];
        end
        return r;
    endfunction

    // Mode decode
    assign busWidthSelect = channelControl[CTL_BW_HI:CTL_BW_LO];
    assign channelActive = channelControl[CTL_ON];
    assign channelPriority = channelControl[CTL_PRIO_HI:CTL_PRIO_LO];
    assign mSize = busWidthSelect;
    assign ctlMerged = merge16(channelControl, avsWriteData, avsByteEnable) & CTL_WMASK;

    // Item offset: index times item size; reserved width steps as bytes
    always_comb
    begin
        stepOffset = {16'h0000, itemIndex};
        case (busWidthSelect)
            BW_HALF: stepOffset = {15'h0000, itemIndex, 1'h0}; // [RQ17]
            BW_WORD: stepOffset = {14'h0000, itemIndex, 2'h0}; // [RQ17]
            default: stepOffset = {16'h0000, itemIndex};
        endcase
    end

    // Fill mode never steps the source, only one fetch is made
    assign srcAddr = {sourceBaseHigh, sourceBaseLow} +
        ((channelControl[CTL_SRC_INC] && !channelControl[CTL_FILL]) ? stepOffset : RST_REG32); // [RQ3]
    assign dstAddr = {destBaseHigh, destBaseLow} +
        (channelControl[CTL_DST_INC] ? stepOffset : RST_REG32); // [RQ3]

    // Request qualification: level as is, or a latched rising edge
    assign reqSeen = channelControl[CTL_EDGE] ? reqPend : dmaReq; // [RQ9]
    assign startItem = (state == ST_IDLE) && channelActive &&
        (!channelControl[CTL_TRIG] || reqSeen); // [RQ20]
    assign itemDone = (state == ST_WRITE) && !mWaitrequest;
    assign lastItem = (itemIndex == transferLengthValue); // [RQ8]
    assign stopAtEnd = !(channelControl[CTL_CIRC] && channelControl[CTL_TRIG]); // [RQ18]

    // Lock for blocking copies and for fill; idle cycles release it
    assign busLock = channelActive && (state != ST_GAP) && (channelControl[CTL_FILL] ||
        (!channelControl[CTL_TRIG] && !channelControl[CTL_YIELD])); // [RQ12] [RQ14] [RQ16]
    assign mRead = (state == ST_READ);
    assign mWrite = (state == ST_WRITE);
    assign mWriteData = dataHold;

    // Slave reads take one wait cycle so read data come from a flop
    assign avsWaitrequest = avsRead && !rdValid;

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            rdValid <= 1'b0;
            avsReadData <= RST_REG32;
        end
        else
        begin
            rdValid <= avsRead && !rdValid;
            case (avsAddress)
                S_IDX: avsReadData <= {16'h0000, itemIndex}; // [RQ1]
                S_SRC_LO: avsReadData <= {16'h0000, sourceBaseLow};
                S_SRC_HI: avsReadData <= {16'h0000, sourceBaseHigh};
                S_DST_LO: avsReadData <= {16'h0000, destBaseLow};
                S_DST_HI: avsReadData <= {16'h0000, destBaseHigh};
                S_INT: avsReadData <= {16'h0000, interruptMatchCount};
                S_LEN: avsReadData <= {16'h0000, transferLengthValue};
                S_CTL: avsReadData <= {16'h0000, channelControl};
                default: avsReadData <= RST_REG32;
            endcase
        end
    end

    // Start addresses, match count and length
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            sourceBaseLow <= RST_REG16;
            sourceBaseHigh <= RST_REG16;
            destBaseLow <= RST_REG16;
            destBaseHigh <= RST_REG16;
            interruptMatchCount <= RST_REG16;
            transferLengthValue <= RST_REG16;
        end
        else if (avsWrite)
        begin
            case (avsAddress)
                S_SRC_LO: sourceBaseLow <= merge16(sourceBaseLow, avsWriteData, avsByteEnable); // [RQ4]
                S_SRC_HI: sourceBaseHigh <= merge16(sourceBaseHigh, avsWriteData, avsByteEnable); // [RQ4]
                S_DST_LO: destBaseLow <= merge16(destBaseLow, avsWriteData, avsByteEnable); // [RQ5]
                S_DST_HI: destBaseHigh <= merge16(destBaseHigh, avsWriteData, avsByteEnable); // [RQ5]
                S_INT: interruptMatchCount <= merge16(interruptMatchCount, avsWriteData, avsByteEnable);
                S_LEN: transferLengthValue <= merge16(transferLengthValue, avsWriteData, avsByteEnable);
                default: ;
            endcase
        end
    end

    // Control; completion clearing the run bit beats a same-cycle write
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            channelControl <= RST_REG16;
        end
        else
        begin
            if (avsWrite && (avsAddress == S_CTL))
            begin
                channelControl <= ctlMerged;
            end
            if (itemDone && lastItem && stopAtEnd)
            begin
                channelControl[CTL_ON] <= 1'b0; // [RQ18]
            end
        end
    end

    // Item index: advance per item, zero at completion or fresh start
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            itemIndex <= RST_REG16;
        end
        else if (itemDone)
        begin
            itemIndex <= lastItem ? RST_REG16 : itemIndex + 16'h0001; // [RQ2] [RQ19]
        end
        else if (avsWrite && (avsAddress == S_CTL) && ctlMerged[CTL_ON] && !channelActive)
        begin
            itemIndex <= RST_REG16;
        end
    end

    // Match compare uses the index before it advances
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            irqPulse <= 1'b0;
            dmaAck <= 1'b0;
        end
        else
        begin
            irqPulse <= itemDone && (interruptMatchCount == itemIndex) &&
                channelControl[CTL_IRQ_EN]; // [RQ6] [RQ7]
            dmaAck <= itemDone && channelControl[CTL_TRIG];
        end
    end

    // Edge capture; a new edge wins over the consume of the old one
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            reqPrev <= 1'b0;
            reqPend <= 1'b0;
        end
        else
        begin
            reqPrev <= dmaReq;
            if (dmaReq && !reqPrev)
            begin
                reqPend <= 1'b1; // [RQ9]
            end
            else if (startItem)
            begin
                reqPend <= 1'b0;
            end
        end
    end

    // Transfer sequencer; software stop takes effect between items
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            state <= ST_IDLE;
            mAddress <= RST_REG32;
            dataHold <= RST_REG32;
        end
        else
        begin
            case (state)
                ST_IDLE:
                begin
                    if (startItem)
                    begin
                        if (channelControl[CTL_FILL] && (itemIndex != RST_REG16))
                        begin
                            state <= ST_WRITE; // [RQ10]
                            mAddress <= dstAddr;
                        end
                        else
                        begin
                            state <= ST_READ;
                            mAddress <= srcAddr;
                        end
                    end
                end
                ST_READ:
                begin
                    if (!mWaitrequest)
                    begin
                        dataHold <= mReadData;
                        mAddress <= dstAddr;
                        state <= ST_WRITE;
                    end
                end
                ST_WRITE:
                begin
                    if (!mWaitrequest)
                    begin
                        if (channelControl[CTL_YIELD] && !channelControl[CTL_TRIG] &&
                            !channelControl[CTL_FILL]) // [RQ12]
                        begin
                            state <= ST_GAP; // [RQ15] [RQ16]
                        end
                        else
                        begin
                            state <= ST_IDLE; // [RQ14]
                        end
                    end
                end
                ST_GAP:
                begin
                    state <= ST_IDLE;
                end
                default:
                begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    property p_idx_clear;
        @(posedge clk) disable iff (!resetn)
        (itemDone && lastItem) |=> (itemIndex == 16'h0000);
    endproperty
    a_idx_clear: assert property (p_idx_clear) else $error("index not cleared"); // [RQ2]

    property p_irq_match;
        @(posedge clk) disable iff (!resetn)
        (itemDone && (interruptMatchCount == itemIndex) && channelControl[CTL_IRQ_EN])
            |=> irqPulse;
    endproperty
    a_irq_match: assert property (p_irq_match) else $error("missed match interrupt"); // [RQ6]

    property p_irq_gate;
        @(posedge clk) disable iff (!resetn)
        irqPulse |-> ($past(channelControl[CTL_IRQ_EN]) && $past(itemDone));
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("interrupt while disabled"); // [RQ7]

    property p_len_end;
        @(posedge clk) disable iff (!resetn)
        (itemDone && !lastItem) |=> (itemIndex == $past(itemIndex) + 16'h0001);
    endproperty
    a_len_end: assert property (p_len_end) else $error("wrong item count"); // [RQ8]

    property p_run_clear;
        @(posedge clk) disable iff (!resetn)
        (itemDone && lastItem && stopAtEnd) |=> !channelActive;
    endproperty
    a_run_clear: assert property (p_run_clear) else $error("run bit stayed set"); // [RQ18]

    property p_circ_keep;
        @(posedge clk) disable iff (!resetn)
        (itemDone && lastItem && !stopAtEnd && !(avsWrite && avsAddress == S_CTL))
            |=> channelActive;
    endproperty
    a_circ_keep: assert property (p_circ_keep) else $error("circular run dropped"); // [RQ19]

    property p_gap;
        @(posedge clk) disable iff (!resetn)
        (itemDone && channelControl[CTL_YIELD] && !channelControl[CTL_TRIG] &&
            !channelControl[CTL_FILL]) |=> (!mRead && !mWrite && !busLock);
    endproperty
    a_gap: assert property (p_gap) else $error("no idle cycle after store"); // [RQ15]

    property p_lock;
        @(posedge clk) disable iff (!resetn)
        ((mRead || mWrite) && channelControl[CTL_FILL]) |-> busLock;
    endproperty
    a_lock: assert property (p_lock) else $error("fill lost bus lock"); // [RQ12]

    property p_block;
        @(posedge clk) disable iff (!resetn)
        (itemDone && !lastItem && !channelControl[CTL_YIELD] && !channelControl[CTL_TRIG])
            |=> busLock;
    endproperty
    a_block: assert property (p_block) else $error("blocking copy released bus"); // [RQ14]

    property p_fill_fetch;
        @(posedge clk) disable iff (!resetn)
        (mRead && channelControl[CTL_FILL]) |-> (itemIndex == 16'h0000);
    endproperty
    a_fill_fetch: assert property (p_fill_fetch) else $error("fill refetched source"); // [RQ10]

    property p_dst_fixed;
        @(posedge clk) disable iff (!resetn)
        (mWrite && !channelControl[CTL_DST_INC]) |-> (mAddress == {destBaseHigh, destBaseLow});
    endproperty
    a_dst_fixed: assert property (p_dst_fixed) else $error("fixed destination moved"); // [RQ3]

    property p_paced;
        @(posedge clk) disable iff (!resetn)
        ($rose(mRead) && channelControl[CTL_TRIG] && !channelControl[CTL_EDGE])
            |-> $past(dmaReq);
    endproperty
    a_paced: assert property (p_paced) else $error("unpaced triggered fetch"); // [RQ20]

endmodule

// [dci_mem_model.sv]
`timescale 1ns/1ps
module dci_mem_model (
    input wire logic clk,
    input wire logic resetn,
    input wire logic slow,
    input wire logic [31:0] mAddress,
    input wire logic mRead,
    input wire logic mWrite,
    input wire logic [31:0] mWriteData,
    output logic [31:0] mReadData,
    output logic mWaitrequest
);
    logic [31:0] lastData = 32'h00000000;
    logic [31:0] stAddr[$];
    logic [31:0] stData[$];
    int reads = 0;

    // Content follows the address, so every fetch can be predicted
    function automatic logic [31:0] memWord(input logic [31:0] a);
        return {a[15:0] ^ 16'h5A5A, ~a[31:16]};
    endfunction

    // Outside an accepted read the bus shows the inverse of the last word
    assign mReadData = (mRead && !mWaitrequest) ? memWord(mAddress) : ~lastData;

    // Random stalls when slow; a request that does not hold gets wrong data
    initial mWaitrequest = 1'b0;
    always @(posedge clk)
    begin
        mWaitrequest <= resetn && slow && ($urandom_range(0, 2) != 0);
        if (mRead && !mWaitrequest)
        begin
            lastData <= memWord(mAddress);
            reads <= reads + 1;
        end
        if (mWrite && !mWaitrequest)
        begin
            stAddr.push_back(mAddress);
            stData.push_back(mWriteData);
        end
    end
endmodule

// [dma_channel_index_and_control_test.sv]
`timescale 1ns/1ps
module dma_channel_index_and_control_test;
    import dci_pkg::*;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [2:0] avsAddress = 3'h0;
    logic avsRead = 1'b0;
    logic avsWrite = 1'b0;
    logic [31:0] avsWriteData = 32'h00000000;
    logic [31:0] avsReadData, mAddress, mWriteData, mReadData;
    logic avsWaitrequest, mRead, mWrite, mWaitrequest, busLock, dmaAck, irqPulse, channelActive;
    logic [1:0] mSize;
    logic [2:0] channelPriority;
    logic dmaReq = 1'b0;
    logic slow = 1'b0;
    int mismatches = 0;
    int testsRun = 0;
    int cycles = 0;
    int gaps = 0;
    int irqs = 0;
    int acks = 0;
    logic storeAgo1 = 1'b0;
    logic storeAgo2 = 1'b0;

    always #2.5 clk = ~clk;

    dci_channel dut (.clk(clk), .resetn(resetn), .avsAddress(avsAddress), .avsRead(avsRead),
        .avsWrite(avsWrite), .avsWriteData(avsWriteData), .avsByteEnable(4'h3),
        .avsReadData(avsReadData), .avsWaitrequest(avsWaitrequest), .mAddress(mAddress),
        .mRead(mRead), .mWrite(mWrite), .mWriteData(mWriteData), .mReadData(mReadData),
        .mWaitrequest(mWaitrequest), .mSize(mSize), .busLock(busLock),
        .channelPriority(channelPriority), .dmaReq(dmaReq), .dmaAck(dmaAck),
        .irqPulse(irqPulse), .channelActive(channelActive));

    dci_mem_model mem (.clk(clk), .resetn(resetn), .slow(slow), .mAddress(mAddress),
        .mRead(mRead), .mWrite(mWrite), .mWriteData(mWriteData), .mReadData(mReadData),
        .mWaitrequest(mWaitrequest));

    // Running tallies; the flow compares differences, so nothing ever clears them
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        storeAgo1 <= (mWrite === 1'b1) && (mWaitrequest === 1'b0);
        storeAgo2 <= storeAgo1;
        // Still idle two cycles after a store: one beyond the normal turnaround
        if (channelActive === 1'b1 && storeAgo2 && !mRead && !mWrite)
            gaps <= gaps + 1;
        if (irqPulse === 1'b1)
            irqs <= irqs + 1;
        if (dmaAck === 1'b1)
            acks <= acks + 1;
        if (cycles == 40000)
        begin
            mismatches++;
            summarize();
        end
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        testsRun++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic summarize();
        $display("Comparisons %0d mismatches %0d", testsRun, mismatches);
        if (mismatches == 0 && testsRun > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // One register access; a spare edge after release avoids re-raising in one step
    task automatic bus(input logic wr, input logic [2:0] a, input logic [15:0] d,
        output logic [15:0] q);
        avsAddress <= a;
        avsWriteData <= {16'h0000, d};
        avsWrite <= wr;
        avsRead <= !wr;
        do
            @(posedge clk);
        while (avsWaitrequest !== 1'b0);
        q = avsReadData[15:0];
        avsWrite <= 1'b0;
        avsRead <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        logic [15:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rdChk(input string what, input logic [2:0] a, input logic [15:0] exp);
        logic [15:0] q;
        bus(1'b0, a, 16'h0000, q);
        check(what, {16'h0000, q}, {16'h0000, exp});
    endtask

    function automatic int step(input logic [1:0] w);
        return w == BW_HALF ? 2 : (w == BW_WORD ? 4 : 1);
    endfunction

    // Bounded wait for the run bit to drop
    task automatic waitDone();
        int n;
        n = 0;
        while (channelActive !== 1'b0 && n < 3000)
        begin
            @(posedge clk);
            n++;
        end
        check("run bit cleared", {31'h0, channelActive}, 32'h0);
    endtask

    // Memory-to-memory run; every store is checked against its predicted place
    task automatic xfer(input logic [31:0] src, input logic [31:0] dst, input logic [15:0] len,
        input logic [15:0] match, input logic [15:0] ctl);
        int g, ir, rd, st;
        logic [31:0] sa;
        g = gaps;
        ir = irqs;
        rd = mem.reads;
        st = step(ctl[2:1]);
        mem.stAddr.delete();
        mem.stData.delete();
        wr(3'h1, src[15:0]);
        wr(3'h2, src[31:16]);
        wr(3'h3, dst[15:0]);
        wr(3'h4, dst[31:16]);
        wr(3'h5, match);
        wr(3'h6, len);
        wr(3'h7, ctl);
        waitDone();
        rdChk("index after run", 3'h0, 16'h0000);
        rdChk("control after run", 3'h7, ctl & 16'h3FFE);
        check("store count", mem.stAddr.size(), len + 1);
        for (int i = 0; i <= len; i++)
        begin
            sa = src + ((ctl[6] && !ctl[12]) ? 32'(i * st) : 32'h0);
            check("store address", mem.stAddr[i], dst + (ctl[5] ? 32'(i * st) : 32'h0));
            check("store data", mem.stData[i], mem.memWord(sa));
        end
        check("fetch count", mem.reads - rd, ctl[12] ? 1 : len + 1);
        check("interrupts", irqs - ir, (ctl[3] && match <= len) ? 1 : 0);
        if (ctl[11] && !ctl[12])
            check("yield gaps", gaps - g, len);
        else
            check("locked gaps", gaps - g, 0);
    endtask

    initial
    begin
        logic [15:0] v;
        logic [15:0] c;
        logic [15:0] n;
        int a0;
        int g;
        void'($urandom(32'h0A4C));
        repeat (10) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        // Everything comes out of reset cleared
        for (int a = 0; a < 8; a++)
            rdChk("reset value", 3'(a), 16'h0000);
        for (int a = 1; a < 7; a++)
        begin
            v = 16'($urandom);
            wr(3'(a), v);
            rdChk("register readback", 3'(a), v);
        end
        c = 16'($urandom) & 16'hFFFE;
        wr(3'h7, c);
        rdChk("control readback", 3'h7, c & 16'h3FFF);
        check("priority pins", channelPriority, c[10:8]);
        check("size pins", mSize, c[2:1]);
        wr(3'h0, 16'hFFFF);
        rdChk("index write ignored", 3'h0, 16'h0000);
        // Single-item fill first, then random mixes over all four width codes
        for (int t = 0; t < 12; t++)
        begin
            slow <= t[0];
            n = t == 0 ? 16'h0000 : 16'($urandom_range(1, 7));
            c = (16'($urandom) & 16'h1F6E) | 16'h0001;
            c[2:1] = 2'(t);
            if (t == 0)
                c[12] = 1'b1;
            if (c[12])
                c[5] = 1'b1;
            xfer($urandom, $urandom, n, 16'($urandom_range(0, 32'(n) + 1)), c);
        end
        // Paced run: nothing without a request, one item per rising edge
        mem.stAddr.delete();
        a0 = acks;
        wr(3'h6, 16'h0003);
        wr(3'h7, 16'h2875);
        repeat (20) @(posedge clk);
        check("no request no store", mem.stAddr.size(), 0);
        dmaReq <= 1'b1;
        repeat (40) @(posedge clk);
        check("stores per edge", mem.stAddr.size(), 1);
        rdChk("index mid run", 3'h0, 16'h0001);
        wr(3'h0, 16'h0000);
        rdChk("index still read only", 3'h0, 16'h0001);
        dmaReq <= 1'b0;
        repeat (4) @(posedge clk);
        dmaReq <= 1'b1;
        repeat (40) @(posedge clk);
        check("stores after second edge", mem.stAddr.size(), 2);
        check("acks", acks - a0, 2);
        // Level sensing with the held request drains the rest, yield bit ignored
        g = gaps;
        wr(3'h7, 16'h0875);
        waitDone();
        check("level stores", mem.stAddr.size(), 4);
        check("paced gaps", gaps - g, 0);
        check("word step", mem.stAddr[3] - mem.stAddr[0], 12);
        // Circular paced run wraps to the start address and stays on
        mem.stAddr.delete();
        wr(3'h6, 16'h0001);
        wr(3'h7, 16'h00B5);
        repeat (60) @(posedge clk);
        rdChk("circular run bit", 3'h7, 16'h00B5);
        dmaReq <= 1'b0;
        check("wrap address", mem.stAddr[2], mem.stAddr[0]);
        wr(3'h7, 16'h0000);
        waitDone();
        summarize();
    end
endmodule
